/* logic/psm_pkg.sv */
// psm_pkg: constants and types for the power saving mode controller
// assumes a single 100 MHz system clock and a wishbone register port
package psm_pkg;
  // register word offsets (byte addresses)
  localparam logic [3:0] CTRL_ADDR   = 4'h0;
  localparam logic [3:0] STATUS_ADDR = 4'h4;
  // control register field positions
  localparam int SLOW_EN_BIT    = 0;
  localparam int SLOW_DIV_LSB   = 1;
  localparam int TB_IRQ_EN_BIT  = 3;
  localparam int LONG_DLY_BIT   = 4;
  localparam int WDG_HALT_BIT   = 5;
  localparam logic [5:0] CTRL_RESET = 6'h00;
  // forced interrupt mask level during low power modes
  localparam logic [1:0] MASK_LOW_POWER = 2'h2;
  // stabilisation counts in core cycles
  localparam int DLY_SHORT_CYC = 256;
  localparam int DLY_LONG_CYC  = 4096;
  localparam int DLY_W         = 13;
  // master clock divider width
  localparam int DIV_W = 5;
  typedef enum logic [2:0] {
    PSM_RUN, PSM_WAIT, PSM_AHALT, PSM_HALT, PSM_STAB
  } psm_state_t;
endpackage : psm_pkg

/* logic/psm_div_if.sv */
// psm_div_if: clock enable divider request and ticks
// assumes both ends share clk_i
`timescale 1ns/10ps
interface psm_div_if;
  logic       slow_en;
  logic [1:0] sel;
  logic       run;
  logic       master_tick;
  logic       core_tick;
  modport ctl (output slow_en, sel, run, input master_tick, core_tick);
  modport div (input slow_en, sel, run, output master_tick, core_tick);
endinterface : psm_div_if

/* logic/psm_divider.sv */
// psm_divider: master clock enable (osc/2) and slow divided core enable
// assumes clk_i is the main oscillator, stops counting when run is low
`timescale 1ns/10ps
module psm_divider (
  input  wire logic clk_i,
  input  wire logic rst_i,
  psm_div_if.div    dv
);
  logic [psm_pkg::DIV_W-1:0] cnt;
  logic [psm_pkg::DIV_W-1:0] next_cnt;
  logic [psm_pkg::DIV_W-1:0] mask;

  // free counter; master tick every 2 osc cycles, slow tick every 2..16 master
  // mask is a run of low ones (3, 7, 15, 31) so the period is a power of two
  always_comb begin
    mask = psm_pkg::DIV_W'((6'h04 << dv.sel) - 6'h01);        // RULE2
    next_cnt = dv.run ? cnt + 5'h01 : cnt;
    dv.master_tick = dv.run && cnt[0];                       // RULE1
    dv.core_tick = dv.slow_en ? (dv.run && ((cnt & mask) == mask))
                              : dv.master_tick;               // RULE2
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) cnt <= '0;
    else cnt <= next_cnt;
  end
endmodule : psm_divider

/* logic/psm_ctrl.sv */
// psm_ctrl: run, slow, wait, active-halt and halt mode sequencing
// assumes clk_i is the oscillator clock; cpu and peripherals use enables
//
// Function
// RULE1: reset enters run at master clock rate
// RULE2: slow enable and two-bit divide select
// RULE3: wait during slow keeps reduced rate
// RULE4: wait instruction stops cpu, peripherals run
// RULE5: wait forces interrupt mask to binary 10
// RULE6: interrupt or reset leaves wait, vectors
// RULE7: wake interrupt pushes cc, loads priority
// RULE8: halt picks active-halt when timebase enabled
// RULE9: active-halt clocks only oscillator and timebase
// RULE10: active-halt interrupt exit skips stabilisation delay
// RULE11: halt entries force mask, pending wakes
// RULE12: active-halt with timebase suppresses watchdog reset
// RULE13: software keeps timebase enable during delay
// RULE14: reset exit from active-halt waits stabilisation
// RULE15: halt stops oscillator, cpu and peripherals
// RULE16: halt wake restarts oscillator, waits delay
// RULE17: option bit decides halt versus watchdog reset
// RULE18: flash parts wake active-halt on timebase only
// RULE19: peripherals stay gated during stabilisation delay
`timescale 1ns/10ps
module psm_ctrl #(
  parameter bit FLASH_PART = 1'b1
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [31:0] dat_i,
  output      logic [31:0] dat_o,
  input  wire logic        we_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output      logic        ack_o,
  input  wire logic        wfi_exec_i,
  input  wire logic        halt_exec_i,
  input  wire logic        tb_irq_i,
  input  wire logic        wake_irq_i,
  input  wire logic        other_irq_i,
  input  wire logic        ext_reset_i,
  input  wire logic        watchdog_active_i,
  input  wire logic [1:0]  irq_priority_i,
  output      logic        core_clk_en_o,
  output      logic        periph_clk_en_o,
  output      logic        timebase_clk_en_o,
  output      logic        osc_enable_o,
  output      logic        mask_force_o,
  output      logic [1:0]  mask_level_o,
  output      logic        cc_push_o,
  output      logic        vector_reset_o,
  output      logic        vector_irq_o,
  output      logic        watchdog_reset_o
);
  psm_div_if dv ();
  psm_pkg::psm_state_t state, next_state;
  logic [5:0]                 ctrl, next_ctrl;
  logic [psm_pkg::DLY_W-1:0]  dly, next_dly;
  logic                       wake_rst, next_wake_rst;
  logic                       ack, next_ack;
  logic [31:0]                rdat, next_rdat;
  logic                       push, next_push;
  logic                       vrst, next_vrst;
  logic                       virq, next_virq;
  logic                       wrst, next_wrst;
  logic                       slow_on, ahalt_wake, halt_wake, any_irq;
  logic [psm_pkg::DLY_W-1:0]  dly_load;

  // divider enables
  psm_divider u_div (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .dv    (dv)
  );

  // divider controls derived from mode
  always_comb begin
    slow_on = ctrl[psm_pkg::SLOW_EN_BIT];
    dv.slow_en = slow_on;                                            // RULE3
    dv.sel = ctrl[psm_pkg::SLOW_DIV_LSB +: 2];
    dv.run = (state != psm_pkg::PSM_HALT);                           // RULE15
    any_irq = tb_irq_i || wake_irq_i || other_irq_i;
    ahalt_wake = tb_irq_i || (!FLASH_PART && wake_irq_i);            // RULE10 RULE18
    halt_wake = wake_irq_i;                                          // RULE16
    dly_load = ctrl[psm_pkg::LONG_DLY_BIT] ? psm_pkg::DLY_W'(psm_pkg::DLY_LONG_CYC - 1)
                                           : psm_pkg::DLY_W'(psm_pkg::DLY_SHORT_CYC - 1);
  end

  // mode sequencer next state
  always_comb begin
    next_state = state;
    next_dly = dly;
    next_wake_rst = wake_rst;
    next_push = 1'b0;
    next_vrst = 1'b0;
    next_virq = 1'b0;
    next_wrst = 1'b0;
    case (state)
      psm_pkg::PSM_RUN: begin
        if (wfi_exec_i) begin
          next_state = psm_pkg::PSM_WAIT;                            // RULE4
        end else if (halt_exec_i) begin
          if (ctrl[psm_pkg::TB_IRQ_EN_BIT]) begin
            next_state = psm_pkg::PSM_AHALT;                         // RULE8 RULE12
          end else if (watchdog_active_i && !ctrl[psm_pkg::WDG_HALT_BIT]) begin
            next_wrst = 1'b1;                                        // RULE17
          end else begin
            next_state = psm_pkg::PSM_HALT;                          // RULE8
          end
        end
      end
      psm_pkg::PSM_WAIT: begin
        if (ext_reset_i) begin
          next_state = psm_pkg::PSM_RUN;                             // RULE6
          next_vrst = 1'b1;
        end else if (any_irq && dv.core_tick) begin
          next_state = psm_pkg::PSM_RUN;                             // RULE6
          next_push = 1'b1;                                          // RULE7
          next_virq = 1'b1;
        end
      end
      psm_pkg::PSM_AHALT: begin
        if (ext_reset_i) begin
          next_state = psm_pkg::PSM_STAB;                            // RULE14
          next_dly = dly_load;
          next_wake_rst = 1'b1;
        end else if (ahalt_wake) begin
          next_state = psm_pkg::PSM_RUN;                             // RULE10 RULE11
          next_push = 1'b1;
          next_virq = 1'b1;
        end
      end
      psm_pkg::PSM_HALT: begin
        if (ext_reset_i || halt_wake) begin
          next_state = psm_pkg::PSM_STAB;                            // RULE16 RULE11
          next_dly = dly_load;
          next_wake_rst = ext_reset_i;
        end
      end
      psm_pkg::PSM_STAB: begin
        if (dv.core_tick) begin
          if (dly == '0) begin
            next_state = psm_pkg::PSM_RUN;                           // RULE16
            next_vrst = wake_rst;
            next_virq = !wake_rst;
            next_push = !wake_rst;                                   // RULE7
          end else begin
            next_dly = dly - 1'b1;
          end
        end
      end
      default: next_state = psm_pkg::PSM_RUN;
    endcase
  end

  // wishbone slave: single cycle ack, control write, status read
  always_comb begin
    next_ctrl = ctrl;
    next_ack = cyc_i && stb_i && !ack;
    next_rdat = rdat;
    if (cyc_i && stb_i && !ack) begin
      next_rdat = 32'h0000_0000;
      if (we_i && sel_i[0] && adr_i == psm_pkg::CTRL_ADDR) begin
        next_ctrl = dat_i[5:0];
      end else if (!we_i && adr_i == psm_pkg::CTRL_ADDR) begin
        next_rdat = {26'h0, ctrl};
      end else if (!we_i && adr_i == psm_pkg::STATUS_ADDR) begin
        next_rdat = {29'h0, state};
      end
    end
  end

  // register all state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= psm_pkg::PSM_RUN;                                     // RULE1
      ctrl <= psm_pkg::CTRL_RESET;
      dly <= '0;
      wake_rst <= 1'b0;
      ack <= 1'b0;
      rdat <= 32'h0000_0000;
      push <= 1'b0;
      vrst <= 1'b0;
      virq <= 1'b0;
      wrst <= 1'b0;
    end else begin
      state <= next_state;
      ctrl <= next_ctrl;
      dly <= next_dly;
      wake_rst <= next_wake_rst;
      ack <= next_ack;
      rdat <= next_rdat;
      push <= next_push;
      vrst <= next_vrst;
      virq <= next_virq;
      wrst <= next_wrst;
    end
  end

  // clock enables and mask forcing per mode
  always_comb begin
    ack_o = ack;
    dat_o = rdat;
    core_clk_en_o = dv.core_tick && (state == psm_pkg::PSM_RUN
                    || state == psm_pkg::PSM_STAB);                  // RULE4 RULE19
    periph_clk_en_o = dv.core_tick && (state == psm_pkg::PSM_RUN
                      || state == psm_pkg::PSM_WAIT);                // RULE9 RULE19
    timebase_clk_en_o = dv.master_tick && (state != psm_pkg::PSM_STAB); // RULE9
    osc_enable_o = (state != psm_pkg::PSM_HALT);                     // RULE15
    mask_force_o = (state == psm_pkg::PSM_WAIT || state == psm_pkg::PSM_AHALT
                    || state == psm_pkg::PSM_HALT);                  // RULE5 RULE11
    mask_level_o = push ? irq_priority_i : psm_pkg::MASK_LOW_POWER; // RULE7
    cc_push_o = push;
    vector_reset_o = vrst;
    vector_irq_o = virq;
    watchdog_reset_o = wrst;
  end
endmodule : psm_ctrl

/* sim/psm_cpu_model.sv */
// psm_cpu_model: core stand-in issuing wait and halt strobes
// assumes one cmd_i cycle per requested instruction
`timescale 1ns/10ps
module psm_cpu_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [1:0] cmd_i,
  output      logic       wfi_o,
  output      logic       halt_o,
  output      logic [1:0] prio_o
);
  logic next_wfi;
  logic next_halt;
  // decode request into strobes
  always_comb begin
    next_wfi  = (cmd_i == 2'h1) && !rst_i;
    next_halt = (cmd_i == 2'h2) && !rst_i;
  end
  // strobes launched after the edge
  always_ff @(posedge clk_i) begin
    wfi_o  <= next_wfi;
    halt_o <= next_halt;
  end
  // fixed routine priority, timebase enable kept
  assign prio_o = 2'h1;
endmodule : psm_cpu_model

/* sim/psm_ctrl_assertions.sv */
// psm_ctrl_chk: port checks of the mode controller
// assumes bind into psm_ctrl, one clock, sync reset
`timescale 1ns/10ps
module psm_ctrl_chk (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       cyc_i,
  input wire logic       stb_i,
  input wire logic       ack_o,
  input wire logic       wfi_exec_i,
  input wire logic       halt_exec_i,
  input wire logic       watchdog_active_i,
  input wire logic [1:0] irq_priority_i,
  input wire logic       core_clk_en_o,
  input wire logic       periph_clk_en_o,
  input wire logic       timebase_clk_en_o,
  input wire logic       osc_enable_o,
  input wire logic       mask_force_o,
  input wire logic [1:0] mask_level_o,
  input wire logic       cc_push_o,
  input wire logic       vector_irq_o,
  input wire logic       watchdog_reset_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // bus answer and mode relations
  a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack too long");
  a_mask_value: assert property (mask_force_o && !cc_push_o |-> mask_level_o == 2'h2)
    else $error("forced mask wrong");
  a_mask_cause: assert property ($rose(mask_force_o) |-> $past(wfi_exec_i || halt_exec_i))
    else $error("mask forced without cause");
  a_osc_gate: assert property (!osc_enable_o |-> !core_clk_en_o && !periph_clk_en_o
    && !timebase_clk_en_o) else $error("clock while osc off");
  a_halt_entry: assert property ($fell(osc_enable_o) |-> $past(halt_exec_i))
    else $error("osc off without halt");
  a_push_vec: assert property (cc_push_o |-> vector_irq_o)
    else $error("push without vector");
  a_push_level: assert property (cc_push_o |-> mask_level_o == irq_priority_i)
    else $error("push level wrong");
  a_wdg_cause: assert property (watchdog_reset_o |-> $past(halt_exec_i && watchdog_active_i))
    else $error("watchdog reset without cause");
  c_halt: cover property ($fell(osc_enable_o));
  c_push: cover property (cc_push_o);
  c_wdg: cover property (watchdog_reset_o);
endmodule : psm_ctrl_chk
bind psm_ctrl psm_ctrl_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .ack_o(ack_o), .wfi_exec_i(wfi_exec_i), .halt_exec_i(halt_exec_i),
  .watchdog_active_i(watchdog_active_i), .irq_priority_i(irq_priority_i),
  .core_clk_en_o(core_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
  .timebase_clk_en_o(timebase_clk_en_o), .osc_enable_o(osc_enable_o),
  .mask_force_o(mask_force_o), .mask_level_o(mask_level_o), .cc_push_o(cc_push_o),
  .vector_irq_o(vector_irq_o), .watchdog_reset_o(watchdog_reset_o));

/* sim/testbench.sv */
// testbench: wishbone and mode pin stimulus for psm_ctrl
// assumes psm_pkg, design and cpu model compiled first
`timescale 1ns/10ps
module testbench;
  logic        clk_i, rst_i, we_i, cyc_i, stb_i, tbq, wkq, otq, xrst, wdg, wait_interrupt_instruction, hlt;
  logic        ack_o, core_o, per_o, tbe_o, osc_o, mf_o, cc_o, vr_o, vi_o, wr_o;
  logic [3:0]  adr_i, sel;
  logic [31:0] dat_i, dat_o, q;
  logic [1:0]  cmd, pri, ml_o;
  int          errors, total_checks, n, cnt[6];
  psm_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
    .we_i(we_i), .sel_i(sel), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .wfi_exec_i(wait_interrupt_instruction),
    .halt_exec_i(hlt), .tb_irq_i(tbq), .wake_irq_i(wkq), .other_irq_i(otq), .ext_reset_i(xrst),
    .watchdog_active_i(wdg), .irq_priority_i(pri), .core_clk_en_o(core_o),
    .periph_clk_en_o(per_o), .timebase_clk_en_o(tbe_o), .osc_enable_o(osc_o),
    .mask_force_o(mf_o), .mask_level_o(ml_o), .cc_push_o(cc_o), .vector_reset_o(vr_o),
    .vector_irq_o(vi_o), .watchdog_reset_o(wr_o));
  psm_cpu_model u_cpu (.clk_i(clk_i), .rst_i(rst_i), .cmd_i(cmd), .wfi_o(wait_interrupt_instruction), .halt_o(hlt),
    .prio_o(pri));
  // clock source
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // pulse counters
  always @(posedge clk_i) begin
    cnt[0] <= cnt[0] + core_o;
    cnt[1] <= cnt[1] + per_o;
    cnt[2] <= cnt[2] + vi_o;
    cnt[3] <= cnt[3] + vr_o;
    cnt[4] <= cnt[4] + wr_o;
    cnt[5] <= cnt[5] + tbe_o;
  end
  task automatic end_of_test;
    if (errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
    int k;
    adr_i <= a; we_i <= w; dat_i <= d; cyc_i <= 1'b1; stb_i <= 1'b1;
    k = 0;
    do begin @(posedge clk_i); k++; end while (ack_o !== 1'b1 && k < 20);
    q = dat_o;
    if (k >= 20) begin errors++; end_of_test(); end
    cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic wait_ev(input int i, input int lim);
    int b;
    b = cnt[i];
    n = 0;
    while (cnt[i] == b && n < lim) begin @(posedge clk_i); n++; end
    if (n >= lim) begin errors++; end_of_test(); end
  endtask : wait_ev
  task automatic rate(input string nm, input int i, input int c, input int e);
    int b;
    b = cnt[i];
    repeat (c) @(posedge clk_i);
    chk(nm, cnt[i] - b, e);
  endtask : rate
  task automatic op(input logic [1:0] c);
    cmd <= c;
    @(posedge clk_i);
    cmd <= 2'h0;
    repeat (3) @(posedge clk_i);
  endtask : op
  // main sequence
  initial begin
    rst_i = 1; cyc_i = 0; stb_i = 0; we_i = 0; adr_i = 0; dat_i = 0; sel = 4'hf; cmd = 0;
    tbq = 0; wkq = 0; otq = 0; xrst = 0; wdg = 0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(4'h4, 0, 0); chk("state", q, 0);
    rate("core run", 0, 64, 32);
    wb(4'h8, 1, 32'hff); wb(4'h8, 0, 0); chk("unmapped", q, 0);
    for (int k = 0; k < 4; k++) begin
      wb(4'h0, 1, 32'h1 | (k << 1));
      repeat (32) @(posedge clk_i);
      rate("core slow", 0, 128, 128 >> (k + 2));
    end
    wb(4'h0, 0, 0); chk("ctrl", q, 32'h7);
    op(2'h1); wb(4'h4, 0, 0); chk("state", q, 1);
    chk("mask", {mf_o, ml_o}, 3'h6);
    rate("core wait", 0, 128, 0);
    rate("periph wait", 1, 128, 4);
    otq <= 1; wait_ev(2, 64); otq <= 0;
    wb(4'h0, 1, 0); op(2'h2); chk("osc", osc_o, 0);
    wb(4'h4, 0, 0); chk("state", q, 3);
    rate("periph halt", 1, 32, 0);
    wkq <= 1; repeat (20) @(posedge clk_i);
    wb(4'h4, 0, 0); chk("state", q, 4);
    rate("periph stab", 1, 32, 0);
    wait_ev(2, 2000); wkq <= 0; chk("delay", n > 440, 1);
    wb(4'h0, 1, 32'h08); op(2'h2); wb(4'h4, 0, 0); chk("state", q, 2);
    rate("periph ahalt", 1, 32, 0);
    rate("tbase ahalt", 5, 32, 16);
    wkq <= 1; rate("no wake", 2, 32, 0); wkq <= 0;
    tbq <= 1; wait_ev(2, 4); tbq <= 0;
    wdg <= 1; wb(4'h0, 1, 0); op(2'h2); chk("wdg rst", cnt[4], 1);
    wb(4'h0, 1, 32'h20); op(2'h2); wb(4'h4, 0, 0); chk("state", q, 3);
    xrst <= 1; wait_ev(3, 2000); xrst <= 0;
    wb(4'h0, 1, 32'h08); op(2'h2); wb(4'h4, 0, 0); chk("state", q, 2);
    chk("wdg quiet", cnt[4], 1);
    xrst <= 1; wait_ev(3, 2000); xrst <= 0; chk("rst delay", n > 440, 1);
    end_of_test();
  end
endmodule : testbench
